//--- ccd_timing_pkg.sv
// shared constants for the ccd horizontal timing core
package ccd_timing_pkg;

	// ************************************************************
	// timing core geometry
	// ************************************************************
	localparam int          STEPS       = 48;     // edge positions per master period
	localparam int          QUAD_SIZE   = 12;     // positions per quadrant
	localparam logic [5:0]  LAST_STEP   = 6'h2F;  // last edge position
	localparam logic [5:0]  NO_EDGE     = 6'h3F;  // decoded value of an invalid code
	localparam logic [3:0]  QUAD_MAX    = 4'hB;   // highest valid low-nibble code
	localparam int          SEQ_COUNT   = 3;      // blanking sequences per line
	localparam int          TOG_W       = 12;     // toggle position width
	localparam int          TOG_COUNT   = 6;      // toggles, start and stop of each sequence

	// ************************************************************
	// register addresses
	// ************************************************************
	localparam int          NUM_REGS      = 27;   // addresses 0 to 26
	localparam logic [4:0]  ADDR_WRITEMODE = 5'h00; // bank select byte
	localparam logic [4:0]  ADDR_BANK1    = 5'h01;  // first address of bank 1
	localparam logic [4:0]  ADDR_BANK2    = 5'h0E;  // first address of bank 2
	localparam logic [4:0]  ADDR_LAST     = 5'h1A;  // last address
	localparam int          ADDR_TOG_BASE = 1;      // toggle k at 1+2k (low) and 2+2k (high)
	localparam int          ADDR_MASK     = 13;     // blanking mask level byte
	localparam int          ADDR_GATE_DRV = 14;     // gate and last-stage drive and polarity
	localparam int          ADDR_HL_POS   = 15;     // last stage rising edge
	localparam int          ADDR_HL_NEG   = 16;     // last stage falling edge
	localparam int          ADDR_RG_POS   = 17;     // reset gate rising edge
	localparam int          ADDR_RG_NEG   = 18;     // reset gate falling edge
	localparam int          ADDR_H_DRV    = 19;     // phase drive codes
	localparam int          ADDR_H1_POS   = 20;     // phase one rising edge and polarity
	localparam int          ADDR_H1_NEG   = 21;     // phase one falling edge
	localparam int          ADDR_REF_LOC  = 22;     // reference sample position
	localparam int          ADDR_DATA_LOC = 23;     // data sample position

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BANK_SEL_BIT = 0;  // writemode bank select
	localparam int MASK_BIT     = 0;  // blanking mask level
	localparam int RG_DRV_LSB   = 0;  // gate drive code [2:0]
	localparam int RG_POL_BIT   = 3;  // gate polarity
	localparam int HL_DRV_LSB   = 4;  // last stage drive code [6:4]
	localparam int HL_POL_BIT   = 7;  // last stage polarity
	localparam int EVEN_DRV_LSB = 0;  // even phase drive [3:0]
	localparam int ODD_DRV_LSB  = 4;  // odd phase drive [7:4]
	localparam int H_POL_BIT    = 7;  // odd phase polarity

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_GATE_DRV = 8'h33;
	localparam logic [7:0] RST_HL_POS   = 8'h00;
	localparam logic [7:0] RST_HL_NEG   = 8'h18;
	localparam logic [7:0] RST_RG_POS   = 8'h00;
	localparam logic [7:0] RST_RG_NEG   = 8'h18;
	localparam logic [7:0] RST_H_DRV    = 8'h77;
	localparam logic [7:0] RST_H1_POS   = 8'h00;
	localparam logic [7:0] RST_H1_NEG   = 8'h20;
	localparam logic [7:0] RST_REF_LOC  = 8'h20;
	localparam logic [7:0] RST_DATA_LOC = 8'h00;
	localparam logic [7:0] RST_OTHER    = 8'h00;

	// reset value of one register address
	function automatic logic [7:0] reset_value(input int a);
		case (a)
			ADDR_GATE_DRV: reset_value = RST_GATE_DRV;
			ADDR_HL_POS:   reset_value = RST_HL_POS;
			ADDR_HL_NEG:   reset_value = RST_HL_NEG;
			ADDR_RG_POS:   reset_value = RST_RG_POS;
			ADDR_RG_NEG:   reset_value = RST_RG_NEG;
			ADDR_H_DRV:    reset_value = RST_H_DRV;
			ADDR_H1_POS:   reset_value = RST_H1_POS;
			ADDR_H1_NEG:   reset_value = RST_H1_NEG;
			ADDR_REF_LOC:  reset_value = RST_REF_LOC;
			ADDR_DATA_LOC: reset_value = RST_DATA_LOC;
			default:       reset_value = RST_OTHER;
		endcase
	endfunction

	// blanking sequencer states, gray along idle-on-done
	typedef enum logic [1:0] {
		BLANK_IDLE = 2'b00,
		BLANK_ON   = 2'b01,
		BLANK_DONE = 2'b11
	} blank_state_e;

endpackage

//--- serial_reg_bank.sv
// three-wire serial register bank with shadow and active copies
`timescale 1ns/1ns
module serial_reg_bank (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// serial port
	input  wire logic                serial_clock_i,
	input  wire logic                serial_load_strobe_i,
	input  wire logic                serial_data_i,
	// active register contents
	output logic [ccd_timing_pkg::NUM_REGS-1:0][7:0] cfg_o
);

	// ************************************************************
	// state
	// ************************************************************
	logic [ccd_timing_pkg::NUM_REGS-1:0][7:0] shadow;      // bytes loaded this transfer
	logic [ccd_timing_pkg::NUM_REGS-1:0][7:0] next_shadow;
	logic [ccd_timing_pkg::NUM_REGS-1:0][7:0] next_cfg;
	logic [7:0]                               shift;       // byte being assembled
	logic [7:0]                               next_shift;
	logic [2:0]                               bit_cnt;     // bits of the current byte
	logic [2:0]                               next_bit_cnt;
	logic [4:0]                               addr;        // address of the current byte
	logic [4:0]                               next_addr;
	logic                                     sck_q;       // previous serial clock
	logic                                     sl_q;        // previous load strobe
	logic                                     sck_rise;
	logic                                     sl_rise;
	logic [7:0]                               byte_in;

	assign sck_rise = serial_clock_i & ~sck_q;
	assign sl_rise  = serial_load_strobe_i & ~sl_q;
	assign byte_in  = {serial_data_i, shift[7:1]};

	// next values of shifter, address and copies
	always_comb begin
		next_shift   = shift;
		next_bit_cnt = bit_cnt;
		next_addr    = addr;
		next_shadow  = shadow;
		next_cfg     = cfg_o;
		if (serial_load_strobe_i) begin
			// strobe high: frame idle, restart at address 0
			next_bit_cnt = 3'h0;
			next_addr    = ccd_timing_pkg::ADDR_WRITEMODE;
			if (sl_rise) begin
				next_cfg = shadow;
			end
		end else if (sck_rise) begin
			// lsb first shift
			next_shift   = byte_in;
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				next_shadow[addr] = byte_in;
				if (addr == ccd_timing_pkg::ADDR_WRITEMODE) begin
					next_addr = byte_in[ccd_timing_pkg::BANK_SEL_BIT] ?
						ccd_timing_pkg::ADDR_BANK2 : ccd_timing_pkg::ADDR_BANK1;
				end else if (addr != ccd_timing_pkg::ADDR_LAST) begin
					next_addr = addr + 5'h01;
				end
			end
		end
	end

	// register everything
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift   <= 8'h00;
			bit_cnt <= 3'h0;
			addr    <= 5'h00;
			sck_q   <= 1'b0;
			sl_q    <= 1'b1;
			for (int i = 0; i < ccd_timing_pkg::NUM_REGS; i++) begin
				shadow[i] <= ccd_timing_pkg::reset_value(i);
				cfg_o[i]  <= ccd_timing_pkg::reset_value(i);
			end
		end else begin
			shift   <= next_shift;
			bit_cnt <= next_bit_cnt;
			addr    <= next_addr;
			sck_q   <= serial_clock_i;
			sl_q    <= serial_load_strobe_i;
			shadow  <= next_shadow;
			cfg_o   <= next_cfg;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	commit_together_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sl_rise |=> (cfg_o == $past(shadow)))
		else $error("active copy did not take the shadow at load");

	hold_between_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!sl_rise |=> (cfg_o == $past(cfg_o)))
		else $error("active copy changed without load strobe");

endmodule

//--- ccd_horizontal_timing_core.sv
// horizontal, reset gate and sampling timing core for a ccd front end
//
// Operation
// - split each master period into 48 steps
// - 6-bit codes: quadrant plus 0-11 offset
// - reset gate: programmable edges and polarity
// - phase one/three: programmable edges and polarity
// - polarity zero normal, one inverted
// - phases two/four complement one/three
// - sample strobes placed by addresses 22, 23
// - phase drive 4-bit code, zero is off
// - gate/last drive 3-bit code, zero off
// - toggle pairs start and end blanking
// - mask level forces phase levels in blanking
// - three blanking sequences per line, in order
// - everything from master clock, line sync and registers
// - serial loads take effect at strobe rise
// - last stage edges from addresses 15, 16
`timescale 1ns/1ns
module ccd_horizontal_timing_core #(
	parameter int TOG_W = ccd_timing_pkg::TOG_W  // toggle position width
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// timing references
	input  wire logic       master_clock_input_i,
	input  wire logic       line_sync_i,
	// serial port
	input  wire logic       serial_clock_i,
	input  wire logic       serial_load_strobe_i,
	input  wire logic       serial_data_i,
	// ccd clocks
	output logic            reset_gate_pulse_o,
	output logic            horiz_phase_one_o,
	output logic            horiz_phase_two_o,
	output logic            horiz_phase_three_o,
	output logic            horiz_phase_four_o,
	output logic            last_stage_horiz_clock_o,
	// sampling strobes and blanking
	output logic            reference_sample_strobe_o,
	output logic            data_sample_strobe_o,
	output logic            line_blanking_o,
	// driver strength and enables, enable low while driving
	output logic [3:0]      odd_phase_drive_code_o,
	output logic [3:0]      even_phase_drive_code_o,
	output logic [2:0]      gate_pulse_drive_code_o,
	output logic [2:0]      last_stage_drive_code_o,
	output logic            odd_phase_oe_n_o,
	output logic            even_phase_oe_n_o,
	output logic            gate_pulse_oe_n_o,
	output logic            last_stage_oe_n_o
);

	// ************************************************************
	// helpers
	// ************************************************************

	// code to edge position, invalid codes never match
	function automatic logic [5:0] edge_pos(input logic [7:0] code);
		logic [5:0] base;
		base = 6'h00;
		case (code[5:4])
			2'h0:    base = 6'h00;
			2'h1:    base = 6'h0C;
			2'h2:    base = 6'h18;
			default: base = 6'h24;
		endcase
		if (code[3:0] > ccd_timing_pkg::QUAD_MAX) begin
			edge_pos = ccd_timing_pkg::NO_EDGE;
		end else begin
			edge_pos = base + {2'b00, code[3:0]};
		end
	endfunction

	// level between rising and falling positions, wraps across the period
	function automatic logic in_window(input logic [5:0] ph, input logic [5:0] r,
		input logic [5:0] f);
		if (r == ccd_timing_pkg::NO_EDGE || f == ccd_timing_pkg::NO_EDGE || r == f) begin
			in_window = 1'b0;
		end else if (r < f) begin
			in_window = (ph >= r) && (ph < f);
		end else begin
			in_window = (ph >= r) || (ph < f);
		end
	endfunction

	// ************************************************************
	// configuration
	// ************************************************************
	logic [ccd_timing_pkg::NUM_REGS-1:0][7:0] cfg;  // active registers
	logic [TOG_W-1:0] tog [ccd_timing_pkg::TOG_COUNT]; // blanking toggles
	logic [7:0]       gate_byte;                    // gate and last-stage byte
	logic [7:0]       drv_byte;                     // phase drive byte
	logic             mask_level;                   // blanking_mask_level

	serial_reg_bank u_regs (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.serial_clock_i       (serial_clock_i),
		.serial_load_strobe_i (serial_load_strobe_i),
		.serial_data_i        (serial_data_i),
		.cfg_o                (cfg)
	);

	// toggle k is a low byte and a high byte
	always_comb begin
		for (int k = 0; k < ccd_timing_pkg::TOG_COUNT; k++) begin
			tog[k] = TOG_W'({cfg[ccd_timing_pkg::ADDR_TOG_BASE + 2*k + 1][3:0],
				cfg[ccd_timing_pkg::ADDR_TOG_BASE + 2*k]});
		end
	end
	assign gate_byte  = cfg[ccd_timing_pkg::ADDR_GATE_DRV];
	assign drv_byte   = cfg[ccd_timing_pkg::ADDR_H_DRV];
	assign mask_level = cfg[ccd_timing_pkg::ADDR_MASK][ccd_timing_pkg::MASK_BIT];

	// ************************************************************
	// phase and pixel counters
	// ************************************************************
	logic             mclk_q;        // previous master clock
	logic             mclk_rise;
	logic [5:0]       phase;         // edge position in period
	logic [5:0]       next_phase;
	logic [TOG_W-1:0] pix;           // master cycles since line start
	logic [TOG_W-1:0] next_pix;

	assign mclk_rise = master_clock_input_i & ~mclk_q;

	// phase realigns on each master rise, else wraps after 47
	always_comb begin
		if (mclk_rise || phase == ccd_timing_pkg::LAST_STEP) begin
			next_phase = 6'h00;
		end else begin
			next_phase = phase + 6'h01;
		end
		// count master cycles from line start
		if (line_sync_i) begin
			next_pix = '0;
		end else if (next_phase == 6'h00 && phase != 6'h00) begin
			next_pix = pix + TOG_W'(1);
		end else begin
			next_pix = pix;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mclk_q <= 1'b0;
			phase  <= 6'h00;
			pix    <= '0;
		end else begin
			mclk_q <= master_clock_input_i;
			phase  <= next_phase;
			pix    <= next_pix;
		end
	end

	// ************************************************************
	// blanking sequencer
	// ************************************************************
	ccd_timing_pkg::blank_state_e bstate;    // current blanking state
	ccd_timing_pkg::blank_state_e next_bstate;
	logic [1:0]                   seq;       // active sequence index
	logic [1:0]                   next_seq;

	always_comb begin
		next_bstate = bstate;
		next_seq    = seq;
		case (bstate)
			ccd_timing_pkg::BLANK_IDLE: begin
				if (pix == tog[2*seq]) begin
					next_bstate = ccd_timing_pkg::BLANK_ON;
				end
			end
			// second toggle ends, move to next sequence, or to done after the last
			ccd_timing_pkg::BLANK_ON: begin
				if (pix == tog[2*seq + 1]) begin
					if (seq == 2'(ccd_timing_pkg::SEQ_COUNT - 1)) begin
						next_bstate = ccd_timing_pkg::BLANK_DONE;
					end else begin
						next_bstate = ccd_timing_pkg::BLANK_IDLE;
						next_seq    = seq + 2'h1;
					end
				end
			end
			// all sequences of this line used
			ccd_timing_pkg::BLANK_DONE: begin
				next_bstate = ccd_timing_pkg::BLANK_DONE;
			end
			default: begin
				next_bstate = ccd_timing_pkg::BLANK_IDLE;
			end
		endcase
		// new line restarts at sequence 0
		if (line_sync_i) begin
			next_bstate = ccd_timing_pkg::BLANK_IDLE;
			next_seq    = 2'h0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bstate <= ccd_timing_pkg::BLANK_IDLE;
			seq    <= 2'h0;
		end else begin
			bstate <= next_bstate;
			seq    <= next_seq;
		end
	end

	// ************************************************************
	// waveform outputs
	// ************************************************************
	logic next_rg;
	logic next_h1;
	logic next_hl;
	logic next_ref;
	logic next_data;
	logic blanking;

	assign blanking = (bstate == ccd_timing_pkg::BLANK_ON);

	always_comb begin
		next_rg = in_window(next_phase, edge_pos(cfg[ccd_timing_pkg::ADDR_RG_POS]),
			edge_pos(cfg[ccd_timing_pkg::ADDR_RG_NEG])) ^ gate_byte[ccd_timing_pkg::RG_POL_BIT];
		next_hl = in_window(next_phase, edge_pos(cfg[ccd_timing_pkg::ADDR_HL_POS]),
			edge_pos(cfg[ccd_timing_pkg::ADDR_HL_NEG])) ^ gate_byte[ccd_timing_pkg::HL_POL_BIT];
		next_h1 = in_window(next_phase, edge_pos(cfg[ccd_timing_pkg::ADDR_H1_POS]),
			edge_pos(cfg[ccd_timing_pkg::ADDR_H1_NEG]))
			^ cfg[ccd_timing_pkg::ADDR_H1_POS][ccd_timing_pkg::H_POL_BIT];
		if (blanking) begin
			next_h1 = mask_level;
		end
		// sample strobes, invalid codes never fire
		next_ref  = (next_phase == edge_pos(cfg[ccd_timing_pkg::ADDR_REF_LOC]));
		next_data = (next_phase == edge_pos(cfg[ccd_timing_pkg::ADDR_DATA_LOC]));
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reset_gate_pulse_o        <= 1'b0;
			horiz_phase_one_o         <= 1'b0;
			horiz_phase_two_o         <= 1'b1;
			horiz_phase_three_o       <= 1'b0;
			horiz_phase_four_o        <= 1'b1;
			last_stage_horiz_clock_o  <= 1'b0;
			reference_sample_strobe_o <= 1'b0;
			data_sample_strobe_o      <= 1'b0;
			line_blanking_o           <= 1'b0;
			odd_phase_drive_code_o    <= 4'h0;
			even_phase_drive_code_o   <= 4'h0;
			gate_pulse_drive_code_o   <= 3'h0;
			last_stage_drive_code_o   <= 3'h0;
			odd_phase_oe_n_o          <= 1'b1;
			even_phase_oe_n_o         <= 1'b1;
			gate_pulse_oe_n_o         <= 1'b1;
			last_stage_oe_n_o         <= 1'b1;
		end else begin
			reset_gate_pulse_o        <= next_rg;
			horiz_phase_one_o         <= next_h1;
			horiz_phase_three_o       <= next_h1;
			horiz_phase_two_o         <= ~next_h1;
			horiz_phase_four_o        <= ~next_h1;
			last_stage_horiz_clock_o  <= next_hl;
			reference_sample_strobe_o <= next_ref;
			data_sample_strobe_o      <= next_data;
			line_blanking_o           <= blanking;
			odd_phase_drive_code_o    <= drv_byte[ccd_timing_pkg::ODD_DRV_LSB +: 4];
			even_phase_drive_code_o   <= drv_byte[ccd_timing_pkg::EVEN_DRV_LSB +: 4];
			odd_phase_oe_n_o          <= (drv_byte[ccd_timing_pkg::ODD_DRV_LSB +: 4] == 4'h0);
			even_phase_oe_n_o         <= (drv_byte[ccd_timing_pkg::EVEN_DRV_LSB +: 4] == 4'h0);
			// gate and last stage drive codes
			gate_pulse_drive_code_o   <= gate_byte[ccd_timing_pkg::RG_DRV_LSB +: 3];
			last_stage_drive_code_o   <= gate_byte[ccd_timing_pkg::HL_DRV_LSB +: 3];
			gate_pulse_oe_n_o         <= (gate_byte[ccd_timing_pkg::RG_DRV_LSB +: 3] == 3'h0);
			last_stage_oe_n_o         <= (gate_byte[ccd_timing_pkg::HL_DRV_LSB +: 3] == 3'h0);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	phase_wrap_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(phase == 6'h2F && !mclk_rise) |=> (phase == 6'h00) ##1 (phase == 6'h01))
		else $error("phase did not wrap after step 47");

	phase_align_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		mclk_rise |=> (phase == 6'h00))
		else $error("phase not realigned on master rise");

	even_complement_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(horiz_phase_two_o == ~horiz_phase_one_o) && (horiz_phase_four_o == ~horiz_phase_three_o))
		else $error("even phases are not the complement");

	mask_force_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		blanking |=> (horiz_phase_one_o == $past(mask_level)) && (line_blanking_o == 1'b1))
		else $error("phase not forced to mask level in blanking");

	ref_place_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		reference_sample_strobe_o |-> ($past(next_phase) ==
			edge_pos($past(cfg[ccd_timing_pkg::ADDR_REF_LOC]))))
		else $error("reference strobe off its position");

	invalid_code_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(cfg[ccd_timing_pkg::ADDR_DATA_LOC][3:0] > 4'hB) |=> !data_sample_strobe_o)
		else $error("data strobe fired on an invalid code");

	gate_polarity_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(cfg[ccd_timing_pkg::ADDR_RG_POS] == cfg[ccd_timing_pkg::ADDR_RG_NEG])
		|=> (reset_gate_pulse_o == $past(gate_byte[3])))
		else $error("empty gate window not at polarity level");

	seq_order_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(seq != $past(seq)) |-> ((seq == $past(seq) + 2'h1)
			|| (seq == 2'h0 && $past(line_sync_i))) && seq < 2'h3)
		else $error("blanking sequence skipped");

	drive_off_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(drv_byte[7:4] == 4'h0) |=> odd_phase_oe_n_o && (odd_phase_drive_code_o == 4'h0))
		else $error("odd phase driven with code zero");

endmodule

//--- ccd_sensor_model.sv
// ccd sensor stand-in that watches the horizontal clock pairs
`timescale 1ns/1ns
module ccd_sensor_model (
	// observed ccd clocks
	input  wire logic clk_i,
	input  wire logic phase_one_i,
	input  wire logic phase_two_i,
	input  wire logic phase_three_i,
	input  wire logic phase_four_i,
	// count of overlapping or unequal phases
	output int        fault_o
);
	initial fault_o = 0;
	always @(negedge clk_i) begin
		if (phase_two_i !== ~phase_one_i || phase_four_i !== ~phase_three_i)
			fault_o <= fault_o + 1;
		else if (phase_three_i !== phase_one_i)
			fault_o <= fault_o + 1;
	end
endmodule

//--- ccd_horizontal_timing_core_tb.sv
// self-checking bench for the ccd horizontal timing core
`timescale 1ns/1ns
module ccd_horizontal_timing_core_tb;
	// stimulus, driven at the falling edge
	logic clk_i = 0, rst_i = 1, mck = 0, lsync = 0, sck = 0, sload = 1, sdat = 0;
	// observed outputs
	logic rg, h1, h2, h3, h4, hl, refs, dats, blk, ooe, eoe, goe, loe, m;
	logic [3:0] odd, even;
	logic [2:0] gdrv, ldrv;
	logic [7:0] dr, g, pdr, pg;
	int fail_count = 0, cmp_count = 0, faults, mcnt = 0, nb, nm, t[6], p[8];
	int n1, nrg, nhl, ir, id, nr, nd;
	always #4 clk_i = ~clk_i;
	// master clock at pixel rate, 48 system cycles
	always @(negedge clk_i) begin
		mcnt <= (mcnt == 47) ? 0 : mcnt + 1;
		mck <= (mcnt < 24);
	end
	ccd_horizontal_timing_core u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.master_clock_input_i(mck), .line_sync_i(lsync), .serial_clock_i(sck),
		.serial_load_strobe_i(sload), .serial_data_i(sdat), .reset_gate_pulse_o(rg),
		.horiz_phase_one_o(h1), .horiz_phase_two_o(h2), .horiz_phase_three_o(h3),
		.horiz_phase_four_o(h4), .last_stage_horiz_clock_o(hl),
		.reference_sample_strobe_o(refs), .data_sample_strobe_o(dats),
		.line_blanking_o(blk), .odd_phase_drive_code_o(odd), .even_phase_drive_code_o(even),
		.gate_pulse_drive_code_o(gdrv), .last_stage_drive_code_o(ldrv),
		.odd_phase_oe_n_o(ooe), .even_phase_oe_n_o(eoe), .gate_pulse_oe_n_o(goe),
		.last_stage_oe_n_o(loe));
	ccd_sensor_model u_ccd (.clk_i(clk_i), .phase_one_i(h1), .phase_two_i(h2),
		.phase_three_i(h3), .phase_four_i(h4), .fault_o(faults));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one byte, lsb first, serial clock two cycles low and three high
	task automatic sbyte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_i);
			sload = 0;
			sdat = b[i];
			sck = 0;
			repeat (2) @(negedge clk_i);
			sck = 1;
			repeat (2) @(negedge clk_i);
		end
	endtask
	task automatic commit;
		sload = 1;
		repeat (4) @(negedge clk_i);
	endtask
	// position to quadrant code
	function automatic logic [7:0] enc(input int x);
		enc = 8'((x / 12) * 16 + x % 12);
	endfunction
	// high cycles of a [rise,fall) window per master period
	function automatic int hi(input int r, input int f, input logic pol);
		hi = (f - r + 48) % 48;
		if (pol) hi = 48 - hi;
	endfunction
	// one master period of observation
	task automatic meas;
		n1 = 0; nrg = 0; nhl = 0; nr = 0; nd = 0;
		for (int i = 0; i < 48; i++) begin
			@(negedge clk_i);
			n1 += (h1 === 1'b1);
			nrg += (rg === 1'b1);
			nhl += (hl === 1'b1);
			if (refs === 1'b1) begin ir = i; nr++; end
			if (dats === 1'b1) begin id = i; nd++; end
		end
	endtask
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
	initial begin
		void'($urandom(24411));
		repeat (4) @(negedge clk_i);
		rst_i = 0;
		@(negedge clk_i);
		pdr = ccd_timing_pkg::RST_H_DRV;
		pg = ccd_timing_pkg::RST_GATE_DRV;
		chk({odd, even, gdrv, ldrv}, {pdr, pg[2:0], pg[6:4]});
		// blanking with both mask levels
		for (int b = 0; b < 2; b++) begin
			m = b[0];
			t[0] = 1 + $urandom % 2;
			for (int k = 1; k < 6; k++) t[k] = t[k-1] + 1 + $urandom % 2;
			sbyte(8'h00);
			for (int k = 0; k < 6; k++) begin
				sbyte(8'(t[k]));
				sbyte(8'h00);
			end
			sbyte({7'h00, m});
			commit();
			lsync = 1;
			@(negedge clk_i);
			lsync = 0;
			nb = 0; nm = 0;
			repeat (768) begin
				@(negedge clk_i);
				nb += (blk === 1'b1);
				nm += (blk === 1'b1 && h1 !== m);
			end
			chk(nb, 48 * (t[1] - t[0] + t[3] - t[2] + t[5] - t[4]));
			chk(nm, 0);
		end
		// random edges, polarities and drive codes
		for (int k = 0; k < 4; k++) begin
			foreach (p[j]) p[j] = $urandom % 48;
			dr = $urandom;
			g = $urandom;
			if (k == 0) dr[7:4] = 4'hF;
			if (k == 1) begin dr[7:4] = 4'h0; g[2:0] = 3'h0; end
			if (k == 2) begin dr[3:0] = 4'h0; g[6:4] = 3'h0; end
			sbyte(8'h01);
			sbyte(g);
			sbyte(enc(p[4]));
			sbyte(k == 3 ? 8'h0D : enc(p[5]));
			sbyte(enc(p[2]));
			sbyte(enc(p[3]));
			sbyte(dr);
			sbyte({g[7], 1'b0, 6'(enc(p[0]))});
			sbyte(enc(p[1]));
			sbyte(enc(p[6]));
			sbyte(enc(p[7]));
			chk({odd, even, gdrv, ldrv}, {pdr, pg[2:0], pg[6:4]});
			commit();
			chk({odd, even, gdrv, ldrv}, {dr, g[2:0], g[6:4]});
			chk({ooe, eoe, goe, loe}, {dr[7:4] == 0, dr[3:0] == 0, g[2:0] == 0, g[6:4] == 0});
			meas();
			chk(n1, hi(p[0], p[1], g[7]));
			chk(nrg, hi(p[2], p[3], g[3]));
			chk(nhl, k == 3 ? (g[7] ? 48 : 0) : hi(p[4], p[5], g[7]));
			chk(nr, 1);
			chk(nd, 1);
			chk((id - ir + 48) % 48, (p[7] - p[6] + 48) % 48);
			pdr = dr;
			pg = g;
		end
		chk(faults, 0);
		stop_test();
	end
endmodule
